// *** qpp_pipeline.sv ***
// Quad-phase clock generator and two-stage fetch/execute sequencer.
// The core clock must be well above twice the external clock input rate.
`timescale 1ns/1ps
module qpp_pipeline (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic reset_n_in,
   // External clock input pin
   input wire logic external_clock_input_in,
   // Program memory
   input wire logic [qpp_pkg::INSN_W-1:0] pm_rdata_in,
   output logic [qpp_pkg::PC_W-1:0] pm_addr_out,
   output logic pm_rd_out,
   // Execution unit
   input wire qpp_pkg::qpp_exec_t exec_in,
   output qpp_pkg::qpp_phases_t phases_out,
   output logic [qpp_pkg::INSN_W-1:0] insn_out,
   output logic insn_valid_out,
   output logic [qpp_pkg::PC_W-1:0] pc_out,
   // Data memory
   output qpp_pkg::qpp_dmem_t dmem_out
);
   import qpp_pkg::*;

   // Synchroniser stages for the external clock input
   logic clk_s1_q;
   logic clk_s2_q;
   logic clk_s3_q;
   // Phase counter and its one-hot strobes
   qpp_phase_t phase_q;
   qpp_phase_t phase_d;
   qpp_phases_t phases_q;
   qpp_phases_t phases_d;
   // Program counter
   logic [PC_W-1:0] pc_q;
   logic [PC_W-1:0] pc_d;
   // Fetch capture and instruction register
   logic [INSN_W-1:0] fetch_q;
   logic [INSN_W-1:0] fetch_d;
   logic [INSN_W-1:0] ir_q;
   logic [INSN_W-1:0] ir_d;
   // Slot state: valid once running, flush after a counter reload
   logic valid_q;
   logic valid_d;
   logic flush_q;
   logic flush_d;
   // Registered data memory strobes
   qpp_dmem_t dmem_q;
   qpp_dmem_t dmem_d;

   // Phase test, shared by every stage of the sequencer
   function automatic logic is_phase(input qpp_phase_t now, input qpp_phase_t want);
      return now == want;
   endfunction : is_phase

   // Next phase in the four-step ring
   function automatic qpp_phase_t next_phase(input qpp_phase_t now);
      return qpp_phase_t'(now + 2'h1);
   endfunction : next_phase

   // Rising edge of the synchronised external clock input
   wire clk_rise;
   // Core edge that leaves phase four and enters phase one
   wire adv_ph1;
   wire end_ph4;
   // Phase the counter holds after this edge
   wire in_ph2_d;
   wire in_ph4_d;
   // Execute effects are suppressed for a flushed slot
   wire live;
   wire take_branch;

   assign clk_rise = clk_s2_q & ~clk_s3_q;
   assign adv_ph1 = clk_rise && is_phase(phase_q, QPP_PH4);
   assign end_ph4 = adv_ph1;
   assign live = valid_q && !flush_q;
   assign take_branch = end_ph4 && live && exec_in.pc_load;

   // Two-flop synchroniser; edge detection looks only at later stages
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         clk_s1_q <= 1'b0;
         clk_s2_q <= 1'b0;
         clk_s3_q <= 1'b0;
      end else begin
         clk_s1_q <= external_clock_input_in;
         clk_s2_q <= clk_s1_q;
         clk_s3_q <= clk_s2_q;
      end
   end

   assign phase_d = clk_rise ? next_phase(phase_q) : phase_q;
   assign phases_d.ph1 = is_phase(phase_d, QPP_PH1);
   assign phases_d.ph2 = is_phase(phase_d, QPP_PH2);
   assign phases_d.ph3 = is_phase(phase_d, QPP_PH3);
   assign phases_d.ph4 = is_phase(phase_d, QPP_PH4);
   assign in_ph2_d = phases_d.ph2;
   assign in_ph4_d = phases_d.ph4;

   // Increment in phase one; load a branch target instead
   assign pc_d = take_branch ? exec_in.pc_target :
                 adv_ph1 ? pc_q + PC_ONE : pc_q;

   // Capture the addressed word at the close of phase four
   assign fetch_d = end_ph4 ? pm_rdata_in : fetch_q;

   // Instruction register takes the word captured at the same edge
   // Fetch and execute overlap, one instruction per cycle
   // A separate stage here would add a cycle of latency to every instruction
   assign ir_d = adv_ph1 ? fetch_d : ir_q;
   assign valid_d = adv_ph1 ? 1'b1 : valid_q;

   // Prefetched word is flushed when the counter is reloaded
   // The first slot after reset holds the word fetched at PC_RESET while parked in phase four; it is flushed too
   assign flush_d = adv_ph1 ? (take_branch || !valid_q) : flush_q;

   // Operand read in phase two, write in phase four
   // A flushed slot touches no data memory
   assign dmem_d.rd = live && in_ph2_d;
   assign dmem_d.wr = live && exec_in.dm_write && in_ph4_d;
   assign dmem_d.addr = exec_in.dm_addr;
   assign dmem_d.wdata = exec_in.dm_wdata;

   // Phase counter parks in phase four so the first edge opens phase one
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         phase_q <= QPP_PH4;
      end else begin
         phase_q <= phase_d;
      end
   end

   // Phase strobes are low in reset; ph4 rises on the first core edge after reset
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         phases_q <= '0;
      end else begin
         phases_q <= phases_d;
      end
   end

   // Program counter
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         pc_q <= PC_RESET;
      end else begin
         pc_q <= pc_d;
      end
   end

   // Fetch capture
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         fetch_q <= INSN_NOP;
      end else begin
         fetch_q <= fetch_d;
      end
   end

   // Instruction register
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         ir_q <= INSN_NOP;
      end else begin
         ir_q <= ir_d;
      end
   end

   // Slot valid
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         valid_q <= 1'b0;
      end else begin
         valid_q <= valid_d;
      end
   end

   // Slot flush
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         flush_q <= 1'b0;
      end else begin
         flush_q <= flush_d;
      end
   end

   // Data memory strobes, registered so they line up with the phase strobes
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         dmem_q <= '0;
      end else begin
         dmem_q <= dmem_d;
      end
   end

   // Outputs
   assign pm_addr_out = pc_q;
   assign pm_rd_out = phases_q.ph4;
   assign phases_out = phases_q;
   assign insn_out = flush_q ? INSN_NOP : ir_q;
   assign insn_valid_out = live;
   assign pc_out = pc_q;
   assign dmem_out = dmem_q;
endmodule : qpp_pipeline

// *** qpp_pkg.sv ***
// Constants and carrier types for the quad-phase fetch/execute pipeline.
// Assumes one core clock; the external clock input is sampled as a pin.
package qpp_pkg;
   localparam int INSN_W = 12;
   localparam int PC_W = 11;
   localparam int DATA_W = 8;
   localparam int DADDR_W = 7;
   localparam logic [PC_W-1:0] PC_RESET = 11'h7ff;
   localparam logic [PC_W-1:0] PC_ONE = 11'h001;
   localparam logic [INSN_W-1:0] INSN_NOP = 12'h000;

   typedef enum logic [1:0] {QPP_PH1, QPP_PH2, QPP_PH3, QPP_PH4} qpp_phase_t;

   // Phase strobes, one hot, each high for one whole phase
   typedef struct packed {
      logic ph1;
      logic ph2;
      logic ph3;
      logic ph4;
   } qpp_phases_t;

   // Execution unit request, decoded externally from the instruction register
   typedef struct packed {
      logic pc_load;
      logic [PC_W-1:0] pc_target;
      logic dm_write;
      logic [DATA_W-1:0] dm_wdata;
      logic [DADDR_W-1:0] dm_addr;
   } qpp_exec_t;

   // Data memory strobes
   typedef struct packed {
      logic rd;
      logic wr;
      logic [DADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } qpp_dmem_t;
endpackage : qpp_pkg

// *** qpp_mem_model.sv ***
// Program memory at the far side of the pipeline.
// Assumes fetches are framed by the read strobe.
`timescale 1ns/1ps
module qpp_mem_model import qpp_pkg::*; (
   input wire logic rd_in,
   input wire logic [PC_W-1:0] addr_in,
   output logic [INSN_W-1:0] rdata_out
);
   // whole word fetch
   // Inverted off the strobe so a mistimed sample shows up
   assign rdata_out = {12{!rd_in}} ^ {1'b1, addr_in} ^ 12'h5a3;
endmodule : qpp_mem_model

// *** qpp_checker.sv ***
// Assertions on the pipeline ports.
// Bound below to every pipeline instance.
`timescale 1ns/1ps
module qpp_checker import qpp_pkg::*; (
   input wire logic core_clk_in, reset_n_in, pm_rd_out, insn_valid_out,
   input wire logic [INSN_W-1:0] insn_out,
   input wire logic [PC_W-1:0] pm_addr_out, pc_out,
   input wire qpp_exec_t exec_in,
   input wire qpp_phases_t phases_out,
   input wire qpp_dmem_t dmem_out
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!reset_n_in);
   one_phase_a: assert property ($onehot0(phases_out)) else $error("overlap");
   phase_len_a: assert property ($rose(phases_out.ph2) |-> phases_out.ph2[*8]) else $error("len");
   pc_step_a: assert property ($changed(pc_out) |-> $rose(phases_out.ph1)) else $error("pc");
   fetch_rd_a: assert property (pm_rd_out == phases_out.ph4 && pc_out == pm_addr_out) else $error("rd");
   ir_hold_a: assert property ($rose(phases_out.ph2) |-> $stable(insn_out)[*8]) else $error("ir");
   dm_rd_a: assert property (dmem_out.rd |-> phases_out.ph2 && insn_valid_out) else $error("dr");
   dm_wr_a: assert property (dmem_out.wr |-> phases_out.ph4 && exec_in.dm_write) else $error("dw");
   flush_nop_a: assert property (!insn_valid_out && phases_out.ph3 |-> !insn_out) else $error("nop");
endmodule : qpp_checker
bind qpp_pipeline qpp_checker chk (.*);

// *** quad_phase_fetch_execute_pipeline_tb.sv ***
// Self-checking bench for the pipeline.
// Assumes the memory model and the bound checker.
`timescale 1ns/1ps
module quad_phase_fetch_execute_pipeline_tb;
   import qpp_pkg::*;
   logic clk = 0, rst_n = 0, ext = 0, p1 = 0, ev = 0, nv = 0, rd, iv;
   logic [INSN_W-1:0] rdat, insn, ei = 0;
   logic [PC_W-1:0] pma, pc, ep = 0;
   qpp_exec_t ex = 0;
   qpp_phases_t ph;
   qpp_dmem_t dm;
   int fail_count = 0, compares = 0, n = 0;
   qpp_pipeline uut (.core_clk_in(clk), .reset_n_in(rst_n), .external_clock_input_in(ext),
      .pm_rdata_in(rdat), .pm_addr_out(pma), .pm_rd_out(rd), .exec_in(ex), .phases_out(ph),
      .insn_out(insn), .insn_valid_out(iv), .pc_out(pc), .dmem_out(dm));
   qpp_mem_model mem (.rd_in(rd), .addr_in(pma), .rdata_out(rdat));
   task chk(input logic [15:0] s, e);
      compares++;
      if (s !== e) begin
         fail_count++;
         $display("mismatch %0t %h %h", $time, s, e);
      end
   endtask : chk
   task print_verdict;
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : print_verdict
   initial forever #5 clk = ~clk;
   // Four core clocks a half period, toggled on rising edges
   initial #5 forever #40 ext = ~ext;
   always @(negedge clk) if (rst_n) begin
      chk(dm.rd, ph.ph2 & ev);
      chk(dm.wr, ph.ph4 & ev & ex.dm_write);
      if (dm.wr) chk({dm.addr, dm.wdata}, {ex.dm_addr, ex.dm_wdata});
      if (ph.ph1 & !p1) begin
         ev = nv;
         chk(pc, ep);
         chk(insn, ei);
         chk(iv, ev);
         ex = qpp_exec_t'(28'($urandom));
         ex.pc_load = $urandom % 4 == 0;
         ei = (ev & ex.pc_load) ? INSN_NOP : {1'b1, ep} ^ 12'h5a3;
         nv = !(ev & ex.pc_load);
         ep = (ev & ex.pc_load) ? ex.pc_target : ep + PC_ONE;
         n++;
      end
      p1 = ph.ph1;
   end
   initial begin
      void'($urandom(32'hd12f48af));
      repeat (3) @(negedge clk);
      rst_n = 1;
      for (int i = 0; i < 2000 && n < 40; i++) @(negedge clk);
      if (n < 40) fail_count++;
      print_verdict;
   end
endmodule : quad_phase_fetch_execute_pipeline_tb
